// ===== rtl/sfc_pkg.sv
// shared constants, register map and carrier types for the sample fifo output block
package sfc_pkg;

  localparam int WORD_W     = 32;
  localparam int HALF_W     = 16;
  localparam int REG_ADDR_W = 8;
  localparam int LOG_W      = 6;
  localparam int IRQ_W      = 2;

  // register byte offsets
  localparam logic [REG_ADDR_W-1:0] REG_CTRL     = 8'h00;
  localparam logic [REG_ADDR_W-1:0] REG_BLK_REQ  = 8'h04;
  localparam logic [REG_ADDR_W-1:0] REG_BLK_EFF  = 8'h08;
  localparam logic [REG_ADDR_W-1:0] REG_STATUS   = 8'h0C;
  localparam logic [REG_ADDR_W-1:0] REG_IRQ_STAT = 8'h10;
  localparam logic [REG_ADDR_W-1:0] REG_IRQ_MASK = 8'h14;
  localparam logic [REG_ADDR_W-1:0] REG_DATA     = 8'h18;

  // reset values
  localparam logic [WORD_W-1:0] BLK_REQ_RESET  = 32'h0000_0400;
  localparam logic [IRQ_W-1:0]  IRQ_MASK_RESET = 2'h0;

  // interrupt status and mask bits
  localparam int IRQ_BLOCK_DONE = 0;
  localparam int IRQ_OVERFLOW   = 1;

  // appended status byte bits
  localparam int ST_OVERLOAD_BIT = 0;
  localparam int ST_ERROR_BIT    = 1;

  // status register fields
  localparam int STAT_OVF_BIT   = 0;
  localparam int STAT_DONE_BIT  = 1;
  localparam int STAT_AVAIL_BIT = 2;
  localparam int STAT_STATE_LSB = 4;
  localparam int STAT_LEVEL_LSB = 8;

  // smallest block is two words (eight bytes) in every format
  localparam logic [LOG_W-1:0] MIN_WORDS_LOG2 = 6'h01;

  // control register, bit 0 is continuousCollect
  typedef struct packed {
    logic run;
    logic blockStatusByteOn;
    logic complexOutputSel;
    logic precisionShort;
    logic blockWrapOn;
    logic routeToLocalBus;
    logic continuousCollect;
  } sfc_ctrl_s;

  localparam int CTRL_W = $bits(sfc_ctrl_s);

  // one fifo entry: data word plus end-of-block mark
  typedef struct packed {
    logic              last;
    logic [WORD_W-1:0] data;
  } sfc_word_s;

  // collection states, gray along idle-collect-status-halt
  typedef enum logic [1:0] {
    ST_IDLE    = 2'h0,
    ST_COLLECT = 2'h1,
    ST_STATUS  = 2'h3,
    ST_HALT    = 2'h2
  } sfc_state_e;

endpackage

// ===== rtl/sfc_word_store.sv
// flip-flop word storage for the sample fifo, one write and one read index
`timescale 1ns/1ps
module sfc_word_store #(
  parameter int WIDTH  = 33,
  parameter int ADDR_W = 10
) (
  input  wire logic              sys_clk,
  input  wire logic              wrEn,
  input  wire logic [ADDR_W-1:0] wrIdx,
  input  wire logic [WIDTH-1:0]  wrData,
  input  wire logic [ADDR_W-1:0] rdIdx,
  output logic      [WIDTH-1:0]  rdData
);

  logic [WIDTH-1:0] mem_r [1 << ADDR_W];

  // data storage needs no reset; pointers outside decide what is valid
  always_ff @(posedge sys_clk) begin
    if (wrEn) begin
      mem_r[wrIdx] <= wrData;
    end
  end

  // read is a plain index into the array; the caller registers it
  assign rdData = mem_r[rdIdx];

endmodule

// ===== rtl/sfc_output_top.sv
// sample collection, formatting, fifo and output routing for a single-channel digitizer
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Summary of operation
// - in single-block mode collection stops as soon as one whole block has been stored.
// - in continuous mode collection runs until the fifo overflows or software returns the block to idle.
// - the route setting sends all output words either to the backplane data register or to the local bus.
// - with block wrap on, the fifo never holds more than one block.
// - with block wrap on, reading past the last word of the block, or past its status word when that is on, restarts at its first word.
// - samples are two's complement, in a 16-bit or a 32-bit format.
// - the 16-bit format packs two values per fifo word so the fifo holds more samples.
// - the type setting selects one real value per sample or a real and imaginary pair.
// - a complex sample is stored real part first, imaginary part right after.
// - block length is the power of two at or below the request, clamped to the minimum and the fifo size, or to half the fifo size with the status byte on.
// - with the status byte on, one word follows each block: bit 0 overload, bit 1 adc error.
module sfc_output_top
  import sfc_pkg::*;
#(
  parameter int FIFO_LOG2 = 10
) (
  input  wire logic                  sys_clk,
  input  wire logic                  resetn,
  input  wire logic [REG_ADDR_W-1:0] regAddr,
  input  wire logic [WORD_W-1:0]     regWdata,
  input  wire logic                  regWr,
  input  wire logic                  regRd,
  output logic      [WORD_W-1:0]     regRdata,
  input  wire logic                  sampleValid,
  input  wire logic [WORD_W-1:0]     sampleRe,
  input  wire logic [WORD_W-1:0]     sampleIm,
  input  wire logic                  adcOverload,
  input  wire logic                  adcError,
  output logic                       lbValid,
  output logic      [WORD_W-1:0]     lbData,
  output logic                       lbLast,
  input  wire logic                  lbReady,
  output logic                       irq
);

  localparam int DEPTH = 1 << FIFO_LOG2;
  typedef logic [FIFO_LOG2:0] sfc_ptr_t;

  sfc_ctrl_s         ctrl_r;
  logic [WORD_W-1:0] blkReq_r;
  logic [IRQ_W-1:0]  irqStat_r;
  logic [IRQ_W-1:0]  irqMask_r;
  sfc_state_e        state_r;
  sfc_ptr_t          wrPtr_r;
  sfc_ptr_t          rdPtr_r;
  sfc_ptr_t          blkCnt_r;
  logic              pendIm_r;
  logic [WORD_W-1:0] imHold_r;
  logic              halfHave_r;
  logic [HALF_W-1:0] halfHold_r;
  logic              ovlBlk_r;
  logic              errBlk_r;
  logic              ovf_r;
  logic              blockDone_r;
  logic              lbValid_r;
  logic [WORD_W-1:0] lbData_r;
  logic              lbLast_r;
  logic [WORD_W-1:0] regRdata_r;

  sfc_ctrl_s         newCtrl;
  logic              adjUp;
  logic              adjDn;
  logic [LOG_W-1:0]  reqLog2;
  logic [LOG_W-1:0]  maxWLog2;
  logic [LOG_W-1:0]  wLog2;
  logic [LOG_W-1:0]  sampleLog2;
  sfc_ptr_t          blkWords;
  sfc_ptr_t          totalWords;
  sfc_ptr_t          occupancy;
  logic              wordReq;
  sfc_word_s         wrWord;
  sfc_word_s         rdWord;
  logic              full;
  logic              wrapFull;
  logic              accept;
  logic              overflowEv;
  logic              blockEnd;
  logic              blockDoneEv;
  logic              ctrlWrite;
  logic              startCmd;
  logic              idleCmd;
  logic              avail;
  logic              bpPop;
  logic              lbLoad;
  logic              memPop;
  logic [WORD_W-1:0] statusWord;

  // highest set bit of a request, zero for zero
  function automatic logic [LOG_W-1:0] floorLog2(input logic [WORD_W-1:0] v);
    logic [LOG_W-1:0] r;
    r = '0;
    for (int i = 0; i < WORD_W; i++) begin
      if (v[i]) begin
        r = LOG_W'(i);
      end
    end
    return r;
  endfunction

  // register address match, used by every access decode
  function automatic logic isReg(input logic [REG_ADDR_W-1:0] a, input logic [REG_ADDR_W-1:0] off);
    return a == off;
  endfunction

  // command decode from a control write
  assign newCtrl   = sfc_ctrl_s'(regWdata[CTRL_W-1:0]);
  assign ctrlWrite = regWr && isReg(regAddr, REG_CTRL);
  assign startCmd  = ctrlWrite && newCtrl.run && (state_r == ST_IDLE || state_r == ST_HALT);
  assign idleCmd   = ctrlWrite && !newCtrl.run;

  // block length in words: long complex doubles it, short real halves it
  assign adjUp    = ctrl_r.complexOutputSel && !ctrl_r.precisionShort;
  assign adjDn    = !ctrl_r.complexOutputSel && ctrl_r.precisionShort;
  assign reqLog2  = floorLog2(blkReq_r);
  // the status word must also fit, so the largest block is halved when it is on
  assign maxWLog2 = ctrl_r.blockStatusByteOn ? LOG_W'(FIFO_LOG2 - 1) : LOG_W'(FIFO_LOG2);

  always_comb begin
    logic [LOG_W-1:0] w;
    w = reqLog2 + LOG_W'(adjUp);
    if (adjDn) begin
      w = (w == '0) ? '0 : w - LOG_W'(1);
    end
    if (w < MIN_WORDS_LOG2) begin
      w = MIN_WORDS_LOG2;
    end
    if (w > maxWLog2) begin
      w = maxWLog2;
    end
    wLog2 = w;
  end

  assign sampleLog2 = wLog2 + LOG_W'(adjDn) - LOG_W'(adjUp);
  assign blkWords   = sfc_ptr_t'(1) << wLog2;
  assign totalWords = blkWords + sfc_ptr_t'(ctrl_r.blockStatusByteOn);

  // formatting of one fifo word per cycle from the current sample
  always_comb begin
    wordReq = 1'b0;
    wrWord  = '0;
    if (state_r == ST_STATUS) begin
      wordReq                      = 1'b1;
      wrWord.last                  = 1'b1;
      wrWord.data[ST_OVERLOAD_BIT] = ovlBlk_r;
      wrWord.data[ST_ERROR_BIT]    = errBlk_r;
    end else if (state_r == ST_COLLECT) begin
      wrWord.last = !ctrl_r.blockStatusByteOn && (blkCnt_r == blkWords - sfc_ptr_t'(1));
      if (pendIm_r) begin
        wordReq     = 1'b1;
        wrWord.data = imHold_r;
      end else if (sampleValid) begin
        if (!ctrl_r.precisionShort) begin
          wordReq     = 1'b1;
          wrWord.data = sampleRe;
        end else if (ctrl_r.complexOutputSel) begin
          wordReq     = 1'b1;
          wrWord.data = {sampleIm[WORD_W-1 -: HALF_W], sampleRe[WORD_W-1 -: HALF_W]};
        end else begin
          wordReq     = halfHave_r;
          wrWord.data = {sampleRe[WORD_W-1 -: HALF_W], halfHold_r};
        end
      end
    end
  end

  // fifo limits: normal occupancy, or one block only when wrapping
  assign occupancy   = wrPtr_r - rdPtr_r;
  assign full        = occupancy == sfc_ptr_t'(DEPTH);
  assign wrapFull    = ctrl_r.blockWrapOn && blockDone_r;
  assign accept      = wordReq && !full && !wrapFull;
  assign overflowEv  = wordReq && (full || wrapFull);
  assign blockEnd    = accept && state_r == ST_COLLECT && blkCnt_r == blkWords - sfc_ptr_t'(1);
  assign blockDoneEv = (blockEnd && !ctrl_r.blockStatusByteOn) || (accept && state_r == ST_STATUS);
  // with wrap the block is readable only once complete, then reads recycle it
  assign avail       = ctrl_r.blockWrapOn ? blockDone_r : (occupancy != '0);

  // output routing: exactly one consumer may pop per route setting
  assign lbLoad = ctrl_r.routeToLocalBus && avail && (!lbValid_r || lbReady);
  assign bpPop  = regRd && isReg(regAddr, REG_DATA) && !ctrl_r.routeToLocalBus && avail;
  assign memPop = lbLoad || bpPop;

  sfc_word_store #(
    .WIDTH  ($bits(sfc_word_s)),
    .ADDR_W (FIFO_LOG2)
  ) u_store (
    .sys_clk (sys_clk),
    .wrEn    (accept),
    .wrIdx   (wrPtr_r[FIFO_LOG2-1:0]),
    .wrData  (wrWord),
    .rdIdx   (rdPtr_r[FIFO_LOG2-1:0]),
    .rdData  (rdWord)
  );

  // collection sequence; software idle beats everything, then a start
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
    end else if (idleCmd) begin
      state_r <= ST_IDLE;
    end else if (startCmd) begin
      state_r <= ST_COLLECT;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          state_r <= ST_IDLE;
        end
        ST_COLLECT: begin
          if (overflowEv) begin
            state_r <= ST_HALT;
          end else if (blockEnd && ctrl_r.blockStatusByteOn) begin
            state_r <= ST_STATUS;
          end else if (blockEnd && !ctrl_r.continuousCollect) begin
            state_r <= ST_HALT;
          end
        end
        ST_STATUS: begin
          if (overflowEv || !ctrl_r.continuousCollect) begin
            state_r <= ST_HALT;
          end else begin
            state_r <= ST_COLLECT;
          end
        end
        ST_HALT: begin
          state_r <= ST_HALT;
        end
      endcase
    end
  end

  // write, read and in-block pointers
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wrPtr_r  <= '0;
      rdPtr_r  <= '0;
      blkCnt_r <= '0;
    end else if (startCmd) begin
      wrPtr_r  <= '0;
      rdPtr_r  <= '0;
      blkCnt_r <= '0;
    end else begin
      if (accept) begin
        wrPtr_r <= wrPtr_r + sfc_ptr_t'(1);
      end
      if (accept && state_r == ST_COLLECT) begin
        blkCnt_r <= blockEnd ? '0 : blkCnt_r + sfc_ptr_t'(1);
      end
      if (memPop && ctrl_r.blockWrapOn && rdPtr_r == totalWords - sfc_ptr_t'(1)) begin
        rdPtr_r <= '0;
      end else if (memPop) begin
        rdPtr_r <= rdPtr_r + sfc_ptr_t'(1);
      end
    end
  end

  // held halves of a sample that spans or shares fifo words
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pendIm_r   <= 1'b0;
      imHold_r   <= '0;
      halfHave_r <= 1'b0;
      halfHold_r <= '0;
    end else if (startCmd) begin
      pendIm_r   <= 1'b0;
      halfHave_r <= 1'b0;
    end else if (state_r == ST_COLLECT) begin
      if (pendIm_r && accept) begin
        pendIm_r <= 1'b0;
      end else if (sampleValid && accept && adjUp) begin
        pendIm_r <= 1'b1;
        imHold_r <= sampleIm;
      end
      if (sampleValid && adjDn && !halfHave_r) begin
        halfHave_r <= 1'b1;
        halfHold_r <= sampleRe[WORD_W-1 -: HALF_W];
      end else if (halfHave_r && accept) begin
        halfHave_r <= 1'b0;
      end
    end
  end

  // adc flags gathered per block; an event in the closing cycle opens the next block
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ovlBlk_r <= 1'b0;
      errBlk_r <= 1'b0;
    end else if (startCmd) begin
      ovlBlk_r <= 1'b0;
      errBlk_r <= 1'b0;
    end else if (blockDoneEv) begin
      ovlBlk_r <= adcOverload;
      errBlk_r <= adcError;
    end else if (state_r == ST_COLLECT) begin
      ovlBlk_r <= ovlBlk_r | adcOverload;
      errBlk_r <= errBlk_r | adcError;
    end
  end

  // overflow and block-complete flags, cleared only by a new start
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ovf_r       <= 1'b0;
      blockDone_r <= 1'b0;
    end else if (startCmd) begin
      ovf_r       <= 1'b0;
      blockDone_r <= 1'b0;
    end else begin
      if (overflowEv) begin
        ovf_r <= 1'b1;
      end
      if (blockDoneEv) begin
        blockDone_r <= 1'b1;
      end
    end
  end

  // software-written settings
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r    <= '0;
      blkReq_r  <= BLK_REQ_RESET;
      irqMask_r <= IRQ_MASK_RESET;
    end else if (regWr) begin
      if (ctrlWrite) begin
        ctrl_r <= newCtrl;
      end
      if (isReg(regAddr, REG_BLK_REQ)) begin
        blkReq_r <= regWdata;
      end
      if (isReg(regAddr, REG_IRQ_MASK)) begin
        irqMask_r <= regWdata[IRQ_W-1:0];
      end
    end
  end

  // sticky events; a read clears, but an event in the same cycle survives it
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      irqStat_r <= '0;
    end else begin
      irqStat_r <= ((regRd && isReg(regAddr, REG_IRQ_STAT)) ? '0 : irqStat_r)
                   | {overflowEv, blockDoneEv};
    end
  end

  assign irq = |(irqStat_r & irqMask_r);

  always_comb begin
    statusWord                                = '0;
    statusWord[STAT_OVF_BIT]                  = ovf_r;
    statusWord[STAT_DONE_BIT]                 = blockDone_r;
    statusWord[STAT_AVAIL_BIT]                = avail;
    statusWord[STAT_STATE_LSB +: 2]           = state_r;
    statusWord[STAT_LEVEL_LSB +: FIFO_LOG2+1] = occupancy;
  end

  // read data stand only in the cycle after the strobe; unmapped reads give zero
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      regRdata_r <= '0;
    end else if (!regRd) begin
      regRdata_r <= '0;
    end else begin
      unique case (1'b1)
        isReg(regAddr, REG_CTRL):     regRdata_r <= WORD_W'(ctrl_r);
        isReg(regAddr, REG_BLK_REQ):  regRdata_r <= blkReq_r;
        isReg(regAddr, REG_BLK_EFF):  regRdata_r <= WORD_W'(1) << sampleLog2;
        isReg(regAddr, REG_STATUS):   regRdata_r <= statusWord;
        isReg(regAddr, REG_IRQ_STAT): regRdata_r <= WORD_W'(irqStat_r);
        isReg(regAddr, REG_IRQ_MASK): regRdata_r <= WORD_W'(irqMask_r);
        isReg(regAddr, REG_DATA):     regRdata_r <= bpPop ? rdWord.data : '0;
        default:                      regRdata_r <= '0;
      endcase
    end
  end

  assign regRdata = regRdata_r;

  // one-word local bus output stage, refilled as the receiver takes each word
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      lbValid_r <= 1'b0;
      lbData_r  <= '0;
      lbLast_r  <= 1'b0;
    end else if (startCmd) begin
      lbValid_r <= 1'b0;
    end else if (lbLoad) begin
      lbValid_r <= 1'b1;
      lbData_r  <= rdWord.data;
      lbLast_r  <= rdWord.last;
    end else if (lbReady) begin
      lbValid_r <= 1'b0;
    end
  end

  assign lbValid = lbValid_r;
  assign lbData  = lbData_r;
  assign lbLast  = lbLast_r;

  // checks on collection, formatting and routing
  property p_single_stop;
    @(posedge sys_clk) disable iff (!resetn)
      (blockEnd && !ctrl_r.continuousCollect && !ctrl_r.blockStatusByteOn && !regWr)
      |=> (state_r == ST_HALT) ##1 (!$past(accept));
  endproperty
  a_single_stop: assert property (p_single_stop) else $error("single block did not stop");

  property p_cont_runs;
    @(posedge sys_clk) disable iff (!resetn)
      (blockEnd && ctrl_r.continuousCollect && !ctrl_r.blockStatusByteOn && !regWr)
      |=> state_r == ST_COLLECT;
  endproperty
  a_cont_runs: assert property (p_cont_runs) else $error("continuous collection stopped");

  property p_route;
    @(posedge sys_clk) disable iff (!resetn)
      memPop |-> (lbLoad != bpPop) && (lbLoad == ctrl_r.routeToLocalBus);
  endproperty
  a_route: assert property (p_route) else $error("word popped on wrong route");

  property p_one_block;
    @(posedge sys_clk) disable iff (!resetn)
      (ctrl_r.blockWrapOn && blockDone_r && wordReq && !regWr) |-> !accept ##1 ovf_r;
  endproperty
  a_one_block: assert property (p_one_block) else $error("second block entered wrap fifo");

  property p_wrap_read;
    @(posedge sys_clk) disable iff (!resetn)
      (memPop && ctrl_r.blockWrapOn && rdPtr_r == totalWords - sfc_ptr_t'(1) && !startCmd)
      |=> rdPtr_r == '0;
  endproperty
  a_wrap_read: assert property (p_wrap_read) else $error("wrap read did not restart");

  // samples come at least three cycles apart, so check the held low half right after capture
  property p_short_pack;
    @(posedge sys_clk) disable iff (!resetn)
      (state_r == ST_COLLECT && adjDn && sampleValid && !halfHave_r && !startCmd && !idleCmd)
      |=> halfHave_r && halfHold_r == $past(sampleRe[WORD_W-1 -: HALF_W]);
  endproperty
  a_short_pack: assert property (p_short_pack) else $error("short samples packed wrongly");

  property p_imag_after_real;
    @(posedge sys_clk) disable iff (!resetn)
      (state_r == ST_COLLECT && adjUp && sampleValid && !pendIm_r && accept && !regWr)
      |=> wordReq && wrWord.data == $past(sampleIm);
  endproperty
  a_imag_after_real: assert property (p_imag_after_real) else $error("imaginary word missing");

  property p_blk_bounds;
    @(posedge sys_clk) disable iff (!resetn)
      wLog2 >= MIN_WORDS_LOG2 && wLog2 <= maxWLog2 && wLog2 <= reqLog2 + LOG_W'(adjUp) + MIN_WORDS_LOG2;
  endproperty
  a_blk_bounds: assert property (p_blk_bounds) else $error("block length out of range");

  property p_status_word;
    @(posedge sys_clk) disable iff (!resetn)
      (state_r == ST_STATUS) |-> wrWord.last && wrWord.data[ST_OVERLOAD_BIT] == ovlBlk_r
        && wrWord.data[ST_ERROR_BIT] == errBlk_r;
  endproperty
  a_status_word: assert property (p_status_word) else $error("status word malformed");

  property p_ovf_hold;
    @(posedge sys_clk) disable iff (!resetn)
      (overflowEv && !startCmd && !idleCmd) |=> ovf_r && state_r == ST_HALT && !accept;
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow not latched");

endmodule

// ===== bench/sfc_lb_sink.sv
// local bus receiver model, accepting at once or with stalls
`timescale 1ns/1ps
module sfc_lb_sink (
  input  wire logic sys_clk,
  input  wire logic resetn,
  input  wire logic slow,
  output logic      lbReady
);
  logic [3:0] cnt_r;
  // while slow, ready on counts 0, 3, 6, 9, 12 and 15 of a 4-bit counter (6 cycles in 16) so words pile up in the fifo
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r   <= 4'h0;
      lbReady <= 1'h0;
    end else begin
      cnt_r   <= cnt_r + 4'h1;
      lbReady <= !slow || (cnt_r % 3 == 0);
    end
  end
endmodule

// ===== bench/sfc_output_top_test.sv
// self-checking bench for the sample fifo output block
`timescale 1ns/1ps
module sfc_output_top_test;
  import sfc_pkg::*;
  localparam int LG = 4;
  logic                  sys_clk, resetn, regWr, regRd, sampleValid, adcOverload, adcError, slow, rdPend;
  logic                  lbValid, lbLast, lbReady, irq;
  logic [REG_ADDR_W-1:0] regAddr;
  logic [WORD_W-1:0]     regWdata, regRdata, sampleRe, sampleIm, lbData, rnd;
  logic [WORD_W-1:0]     w[20];
  logic [63:0]           e;
  logic [63:0]           qReg[$];
  logic [32:0]           qLb[$];
  logic [7:0]            tCfg[9] = '{8'h00, 8'h00, 8'h00, 8'h08, 8'h08, 8'h10, 8'h10, 8'h18, 8'h20};
  logic [7:0]            tReq[9] = '{8'h01, 8'h05, 8'h64, 8'h01, 8'h64, 8'h01, 8'h64, 8'h03, 8'h64};
  logic [7:0]            tEff[9] = '{8'h02, 8'h04, 8'h10, 8'h04, 8'h20, 8'h01, 8'h08, 8'h02, 8'h08};
  int                    fails, n_tests;

  sfc_output_top #(.FIFO_LOG2(LG)) u_dut (.sys_clk(sys_clk), .resetn(resetn), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .sampleValid(sampleValid),
    .sampleRe(sampleRe), .sampleIm(sampleIm), .adcOverload(adcOverload), .adcError(adcError),
    .lbValid(lbValid), .lbData(lbData), .lbLast(lbLast), .lbReady(lbReady), .irq(irq));
  sfc_lb_sink u_sink (.sys_clk(sys_clk), .resetn(resetn), .slow(slow), .lbReady(lbReady));

  // 125 MHz clock
  initial begin
    sys_clk = 1'h0;
    forever #4 sys_clk = ~sys_clk;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic chk(input logic [32:0] g, input logic [32:0] x);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("ERROR %0t got %h expected %h", $time, g, x);
    end
  endtask

  task automatic wr(input logic [REG_ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'h1;
    @(posedge sys_clk);
    regWr    <= 1'h0;
  endtask

  // the note goes in before the strobe, so the watcher always finds it
  task automatic rd(input logic [REG_ADDR_W-1:0] a, input logic [31:0] x, input logic [31:0] m = 32'hFFFF_FFFF);
    qReg.push_back({m, x});
    @(posedge sys_clk);
    regAddr <= a;
    regRd   <= 1'h1;
    @(posedge sys_clk);
    regRd   <= 1'h0;
  endtask

  // the block request and control word, then new random samples for the run
  task automatic st(input sfc_ctrl_s cf, input logic [31:0] req);
    wr(REG_BLK_REQ, req);
    wr(REG_CTRL, WORD_W'(cf));
    for (int i = 0; i < 20; i++) begin
      rnd  = lfsr(rnd);
      w[i] = rnd;
    end
  endtask

  // samples three cycles apart, imaginary part is the inverse of the real part
  task automatic feed(input int lo, input int hi);
    for (int i = lo; i < hi; i++) begin
      @(posedge sys_clk);
      sampleValid <= 1'h1;
      sampleRe    <= w[i];
      sampleIm    <= ~w[i];
      @(posedge sys_clk);
      sampleValid <= 1'h0;
      @(posedge sys_clk);
    end
  endtask

  task automatic lbDone;
    repeat (300) if (qLb.size() != 0) @(posedge sys_clk);
    chk({32'h0, qLb.size() == 0}, 33'h1);
  endtask

  task automatic summarize;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask

  // compare each result with the oldest note of its queue
  always @(posedge sys_clk) begin
    rdPend <= regRd;
    if (rdPend) begin
      e = qReg.pop_front();
      chk({1'h0, regRdata & e[63:32]}, {1'h0, e[31:0]});
    end
    if (lbValid && lbReady) chk({lbLast, lbData}, qLb.size() ? qLb.pop_front() : 'x);
  end

  // cut a hang short; the whole run needs only a few hundred cycles
  initial begin
    repeat (20000) @(posedge sys_clk);
    fails++;
    summarize();
  end

  initial begin
    {regWr, regRd, sampleValid, adcOverload, adcError, slow} = '0;
    regAddr  = '0;
    regWdata = '0;
    sampleRe = '0;
    sampleIm = '0;
    rnd      = 32'h5316;
    resetn   = 1'h0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'h1;
    // reset values, unmapped address, mask, then block length per format
    rd(REG_BLK_REQ, BLK_REQ_RESET);
    rd(REG_IRQ_MASK, 32'h0);
    rd(8'h1C, 32'h0);
    wr(REG_IRQ_MASK, 32'h3);
    rd(REG_IRQ_MASK, 32'h3);
    for (int i = 0; i < 9; i++) begin
      wr(REG_CTRL, {24'h0, tCfg[i]});
      wr(REG_BLK_REQ, {24'h0, tReq[i]});
      rd(REG_BLK_EFF, {24'h0, tEff[i]});
    end
    // single block over the backplane; later samples are dropped
    st('{run: 1'h1, default: 1'h0}, 32'h4);
    feed(0, 6);
    for (int i = 0; i < 4; i++) rd(REG_DATA, w[i]);
    rd(REG_DATA, 32'h0);
    rd(REG_STATUS, 32'h22, 32'h1F37);
    chk({32'h0, lbValid}, 33'h0);
    chk({32'h0, irq}, 33'h1);
    rd(REG_IRQ_STAT, 32'h1);
    #1 chk({32'h0, irq}, 33'h0);
    // complex pairs to a stalling local bus receiver
    slow <= 1'h1;
    st('{run: 1'h1, routeToLocalBus: 1'h1, complexOutputSel: 1'h1, default: 1'h0}, 32'h2);
    for (int i = 0; i < 2; i++) begin
      qLb.push_back({1'h0, w[i]});
      qLb.push_back({i == 1, ~w[i]});
    end
    feed(0, 2);
    rd(REG_DATA, 32'h0);
    lbDone();
    // two packed short blocks, each with its status word: overload in the first, error in the second
    st('{run: 1'h1, routeToLocalBus: 1'h1, precisionShort: 1'h1, blockStatusByteOn: 1'h1,
         continuousCollect: 1'h1, default: 1'h0}, 32'h4);
    for (int i = 0; i < 8; i += 4) begin
      qLb.push_back({1'h0, w[i + 1][31:16], w[i][31:16]});
      qLb.push_back({1'h0, w[i + 3][31:16], w[i + 2][31:16]});
      qLb.push_back({1'h1, 30'h0, i == 4, i == 0});
    end
    feed(0, 2);
    @(posedge sys_clk) adcOverload <= 1'h1;
    @(posedge sys_clk) adcOverload <= 1'h0;
    feed(2, 6);
    @(posedge sys_clk) adcError <= 1'h1;
    @(posedge sys_clk) adcError <= 1'h0;
    feed(6, 8);
    lbDone();
    wr(REG_CTRL, 32'h0);
    slow <= 1'h0;
    // wrapped short complex block: reads cycle round, a second block overflows
    st('{run: 1'h1, blockWrapOn: 1'h1, continuousCollect: 1'h1, precisionShort: 1'h1,
         complexOutputSel: 1'h1, default: 1'h0}, 32'h2);
    feed(0, 2);
    for (int i = 0; i < 5; i++) rd(REG_DATA, {~w[i % 2][31:16], w[i % 2][31:16]});
    feed(2, 3);
    rd(REG_STATUS, 32'h1, 32'h1);
    wr(REG_IRQ_MASK, 32'h0);
    #1 chk({32'h0, irq}, 33'h0);
    wr(REG_IRQ_MASK, 32'h3);
    #1 chk({32'h0, irq}, 33'h1);
    rd(REG_IRQ_STAT, 32'h3);
    #1 chk({32'h0, irq}, 33'h0);
    // continuous run past one block, into overflow, then back to idle
    st('{run: 1'h1, continuousCollect: 1'h1, default: 1'h0}, 32'h4);
    feed(0, 5);
    rd(REG_STATUS, 32'h516, 32'h1F37);
    feed(5, 17);
    rd(REG_STATUS, 32'h1027, 32'h1F37);
    rd(REG_DATA, w[0]);
    wr(REG_CTRL, 32'h0);
    feed(17, 18);
    rd(REG_STATUS, 32'hF00, 32'h1F30);
    repeat (2) @(posedge sys_clk);
    summarize();
  end
endmodule
